// [design/irq_status_regs.svh]
`ifndef IRQ_STATUS_REGS_SVH
`define IRQ_STATUS_REGS_SVH

// register byte addresses
`define MISSED_FLAGS_ADDR    32'h4000_A820
`define UNPEND_ADDR          32'hE000_E280
`define ACTIVE_STATUS_ADDR   32'hE000_E300
`define FAULT_STATUS_ADDR    32'hE000_ED3C
`define EVT_STATUS_ADDR      32'h4000_A830
`define EVT_CLEAR_ADDR       32'h4000_A834
`define EVT_ENABLE_ADDR      32'h4000_A838

// source bit positions
`define SRC_DEBUG_BIT        16
`define SRC_PIN_D_BIT        15
`define SRC_PIN_C_BIT        14
`define SRC_PIN_A_BIT        12
`define SRC_RADIO_RX_BIT     10
`define SRC_RADIO_TX_BIT     9
`define SRC_RADIO_TMR_BIT    8
`define SRC_SECURITY_BIT     7
`define SRC_SERIAL_ONE_BIT   5
`define SRC_SLEEP_TMR_BIT    4
`define SRC_BASEBAND_BIT     3
`define SRC_MGMT_BIT         2

`define SRC_ONE              32'h0000_0001
`define MISS_MASK  ((`SRC_ONE << `SRC_PIN_D_BIT) | (`SRC_ONE << `SRC_PIN_C_BIT) | \
                    (`SRC_ONE << `SRC_PIN_A_BIT) | (`SRC_ONE << `SRC_RADIO_RX_BIT) | \
                    (`SRC_ONE << `SRC_RADIO_TX_BIT) | (`SRC_ONE << `SRC_RADIO_TMR_BIT) | \
                    (`SRC_ONE << `SRC_SECURITY_BIT) | (`SRC_ONE << `SRC_SERIAL_ONE_BIT) | \
                    (`SRC_ONE << `SRC_SLEEP_TMR_BIT) | (`SRC_ONE << `SRC_BASEBAND_BIT) | \
                    (`SRC_ONE << `SRC_MGMT_BIT))
`define SRC_MASK   (`MISS_MASK | (`SRC_ONE << `SRC_DEBUG_BIT))

// fault status bit positions
`define FAULT_SIZE_BIT       3
`define FAULT_PROT_BIT       2
`define FAULT_RSVD_BIT       1
`define FAULT_MISSED_BIT     0

// event status bit positions
`define EVT_LOST_IRQ_BIT     0
`define EVT_BUS_FAULT_BIT    1

// reset values
`define PEND_RST             32'h0000_0000
`define MISSED_RST           32'h0000_0000
`define ACTIVE_RST           32'h0000_0000
`define FAULT_RST            4'h0
`define EVT_RST              2'h0

`endif

// [design/irq_status_pkg.sv]
`default_nettype none

package irq_status_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        logic size_err;
        logic prot_err;
        logic rsvd_err;
    } fault_info_t;

    typedef struct packed {
        logic [31:0] pend;
        logic [31:0] missed;
        logic [31:0] active;
        logic [3:0]  fault;
        logic [1:0]  evt;
        logic [1:0]  evt_en;
        logic        irq;
        logic [31:0] rdata;
    } state_t;

endpackage : irq_status_pkg

`default_nettype wire

// [design/irq_status_and_bus_fault_flags.sv]
// Summary of operation
// RULE1 - a one written to an unpend bit clears that source's pending state
// RULE2 - a zero written to an unpend bit leaves that source's pending state alone
// RULE3 - twelve sources at fixed bit positions; every other bit reads zero
// RULE4 - active register is read only and shows each active source at its bit
// RULE5 - missed flags are read/write at eleven positions, no debug, others read zero
// RULE6 - a new event on an already pending source sets its missed flag
// RULE7 - every register comes out of reset at zero
// RULE8 - bad width or unaligned access fault sets fault bit 3
// RULE9 - unprivileged protected write fault sets fault bit 2
// RULE10 - reserved or out of range address fault sets fault bit 1
// RULE11 - a fault arriving while any fault bit is set sets fault bit 0
// RULE12 - fault bits stay until software writes them; bits 31 to 4 read zero
`timescale 1ns/10ps
`default_nettype none
`include "irq_status_regs.svh"

module irq_status_and_bus_fault_flags #(
    parameter int SRC_W = 17
) (
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    input  wire irq_status_pkg::bus_req_t     bus_i,
    output logic [31:0]                       rdata_o,
    input  wire logic [SRC_W-1:0]             src_event_i,
    input  wire logic [SRC_W-1:0]             pend_set_i,
    input  wire logic [SRC_W-1:0]             active_i,
    input  wire irq_status_pkg::fault_info_t  fault_i,
    output logic [31:0]                       pending_o,
    output logic [31:0]                       missed_o,
    output logic [3:0]                        fault_o,
    output logic                              irq_o
);

    // highest source sits at bit 16; wider than a bus word cannot be served
    if (SRC_W < `SRC_DEBUG_BIT + 1 || SRC_W > 32) begin : g_bad_width
        $error("SRC_W must lie between 17 and 32");
    end

    irq_status_pkg::state_t s_r;
    irq_status_pkg::state_t s_nxt;

    logic [31:0] ev_w;
    logic [31:0] lost_w;
    logic [31:0] unpend_w;
    logic [3:0]  fault_set_w;
    logic [1:0]  evt_set_w;
    logic        wr_unpend_w;
    logic        wr_missed_w;
    logic        wr_fault_w;
    logic        wr_evt_clr_w;
    logic        wr_evt_en_w;

    function automatic logic hit(input irq_status_pkg::bus_req_t req,
                                 input logic [31:0] addr);
        hit = req.addr == addr;
    endfunction : hit

    function automatic logic [31:0] widen(input logic [SRC_W-1:0] v);
        widen = 32'(v) & `SRC_MASK;
    endfunction : widen

    always_comb begin
        s_nxt        = s_r;
        ev_w         = widen(src_event_i);
        wr_unpend_w  = bus_i.wr && hit(bus_i, `UNPEND_ADDR);
        wr_missed_w  = bus_i.wr && hit(bus_i, `MISSED_FLAGS_ADDR);
        wr_fault_w   = bus_i.wr && hit(bus_i, `FAULT_STATUS_ADDR);
        wr_evt_clr_w = bus_i.wr && hit(bus_i, `EVT_CLEAR_ADDR);
        wr_evt_en_w  = bus_i.wr && hit(bus_i, `EVT_ENABLE_ADDR);

        // zero bits of the write leave pending alone
        unpend_w = wr_unpend_w ? (bus_i.wdata & `SRC_MASK) : 32'h0000_0000; // RULE2
        // a fresh event beats a same-cycle unpend so nothing is dropped
        s_nxt.pend = ((s_r.pend & ~unpend_w) | ev_w | widen(pend_set_i)) & `SRC_MASK; // RULE1 RULE3

        lost_w = ev_w & s_r.pend & `MISS_MASK; // RULE6
        if (wr_missed_w) begin
            s_nxt.missed = bus_i.wdata & `MISS_MASK; // RULE5
        end
        s_nxt.missed = s_nxt.missed | lost_w; // RULE6

        // active state is owned by the core; we only mirror it
        s_nxt.active = widen(active_i); // RULE4

        fault_set_w = 4'h0;
        fault_set_w[`FAULT_SIZE_BIT]   = fault_i.valid && fault_i.size_err; // RULE8
        fault_set_w[`FAULT_PROT_BIT]   = fault_i.valid && fault_i.prot_err; // RULE9
        fault_set_w[`FAULT_RSVD_BIT]   = fault_i.valid && fault_i.rsvd_err; // RULE10
        fault_set_w[`FAULT_MISSED_BIT] = fault_i.valid && (|s_r.fault); // RULE11
        if (wr_fault_w) begin
            s_nxt.fault = bus_i.wdata[3:0]; // RULE12
        end
        s_nxt.fault = s_nxt.fault | fault_set_w; // RULE12

        evt_set_w = 2'h0;
        evt_set_w[`EVT_LOST_IRQ_BIT]  = |lost_w;
        evt_set_w[`EVT_BUS_FAULT_BIT] = fault_i.valid;
        if (wr_evt_clr_w) begin
            s_nxt.evt = s_r.evt & ~bus_i.wdata[1:0];
        end
        s_nxt.evt = s_nxt.evt | evt_set_w;
        if (wr_evt_en_w) begin
            s_nxt.evt_en = bus_i.wdata[1:0];
        end
        s_nxt.irq = |(s_nxt.evt & s_nxt.evt_en);

        s_nxt.rdata = 32'h0000_0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `MISSED_FLAGS_ADDR:  s_nxt.rdata = s_r.missed; // RULE5
                `ACTIVE_STATUS_ADDR: s_nxt.rdata = s_r.active; // RULE4
                `FAULT_STATUS_ADDR:  s_nxt.rdata = {28'h000_0000, s_r.fault}; // RULE12
                `EVT_STATUS_ADDR:    s_nxt.rdata = {30'h0000_0000, s_r.evt};
                `EVT_ENABLE_ADDR:    s_nxt.rdata = {30'h0000_0000, s_r.evt_en};
                // unpend and clear are write only and read as zero
                default:             s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r.pend   <= `PEND_RST; // RULE7
            s_r.missed <= `MISSED_RST;
            s_r.active <= `ACTIVE_RST;
            s_r.fault  <= `FAULT_RST;
            s_r.evt    <= `EVT_RST;
            s_r.evt_en <= `EVT_RST;
            s_r.irq    <= 1'b0;
            s_r.rdata  <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o   = s_r.rdata;
    assign pending_o = s_r.pend;
    assign missed_o  = s_r.missed;
    assign fault_o   = s_r.fault;
    assign irq_o     = s_r.irq;

    // checks

    logic [31:0] unpend_keep_w;
    logic [31:0] src_set_w;
    assign unpend_keep_w = ~bus_i.wdata;
    assign src_set_w     = ev_w | widen(pend_set_i);

    sequence s_unpend_write;
        bus_i.wr && bus_i.addr == `UNPEND_ADDR;
    endsequence

    sequence s_fault_arrives;
        fault_i.valid && !(bus_i.wr && bus_i.addr == `FAULT_STATUS_ADDR);
    endsequence

    sequence s_active_read;
        bus_i.rd && bus_i.addr == `ACTIVE_STATUS_ADDR;
    endsequence

    a_unpend_clears: assert property ( // RULE1
        @(posedge clk_i) disable iff (srst_i)
        s_unpend_write |=> (pending_o & $past(bus_i.wdata) & ~$past(src_set_w)) == 32'h0000_0000
    ) else $error("unpend write did not clear pending");

    a_unpend_zero_keeps: assert property ( // RULE2
        @(posedge clk_i) disable iff (srst_i)
        s_unpend_write |=> ($past(pending_o) & $past(unpend_keep_w) & ~pending_o) == 32'h0000_0000
    ) else $error("zero in unpend write changed pending");

    a_reserved_bits_zero: assert property ( // RULE3
        @(posedge clk_i) disable iff (srst_i)
        (pending_o & ~`SRC_MASK) == 32'h0000_0000 && (missed_o & ~`MISS_MASK) == 32'h0000_0000
    ) else $error("reserved source bit set");

    a_active_read_back: assert property ( // RULE4
        @(posedge clk_i) disable iff (srst_i)
        s_active_read ##1 1'b1 |-> rdata_o == (32'($past(active_i, 2)) & `SRC_MASK)
    ) else $error("active read does not match source activity");

    a_missed_flag_write: assert property ( // RULE5
        @(posedge clk_i) disable iff (srst_i)
        bus_i.wr && bus_i.addr == `MISSED_FLAGS_ADDR && !(|lost_w)
        |=> missed_o == ($past(bus_i.wdata) & `MISS_MASK)
    ) else $error("missed flag write not stored");

    a_missed_on_repeat: assert property ( // RULE6
        @(posedge clk_i) disable iff (srst_i)
        |lost_w |=> (missed_o & $past(lost_w)) == $past(lost_w)
    ) else $error("repeat event did not set missed flag");

    a_reset_all_zero: assert property ( // RULE7
        @(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> pending_o == 32'h0000_0000 && missed_o == 32'h0000_0000
                          && fault_o == 4'h0 && rdata_o == 32'h0000_0000 && !irq_o
    ) else $error("register not zero after reset");

    a_size_fault: assert property ( // RULE8
        @(posedge clk_i) disable iff (srst_i)
        fault_i.valid && fault_i.size_err |=> fault_o[`FAULT_SIZE_BIT]
    ) else $error("size fault not flagged");

    a_prot_fault: assert property ( // RULE9
        @(posedge clk_i) disable iff (srst_i)
        fault_i.valid && fault_i.prot_err |=> fault_o[`FAULT_PROT_BIT]
    ) else $error("protection fault not flagged");

    a_rsvd_fault: assert property ( // RULE10
        @(posedge clk_i) disable iff (srst_i)
        fault_i.valid && fault_i.rsvd_err |=> fault_o[`FAULT_RSVD_BIT]
    ) else $error("reserved address fault not flagged");

    a_missed_fault: assert property ( // RULE11
        @(posedge clk_i) disable iff (srst_i)
        s_fault_arrives ##0 (fault_o != 4'h0) |=> fault_o[`FAULT_MISSED_BIT]
        and (fault_o & $past(fault_o)) == $past(fault_o)
    ) else $error("fault on fault not flagged as missed");

    a_fault_sticky: assert property ( // RULE12
        @(posedge clk_i) disable iff (srst_i)
        !(bus_i.wr && bus_i.addr == `FAULT_STATUS_ADDR) |=> (fault_o & $past(fault_o)) == $past(fault_o)
    ) else $error("fault flag dropped without write");

    a_irq_follows_evt: assert property (
        @(posedge clk_i) disable iff (srst_i)
        fault_i.valid && s_r.evt_en[`EVT_BUS_FAULT_BIT] && !bus_i.wr |=> irq_o
    ) else $error("enabled event did not raise interrupt");

    // read and write strobes per register, shared by the checks below
    sequence s_fault_write;
        bus_i.wr && bus_i.addr == `FAULT_STATUS_ADDR;
    endsequence

    sequence s_clear_write;
        bus_i.wr && bus_i.addr == `EVT_CLEAR_ADDR;
    endsequence

    sequence s_enable_write;
        bus_i.wr && bus_i.addr == `EVT_ENABLE_ADDR;
    endsequence

    sequence s_missed_read;
        bus_i.rd && bus_i.addr == `MISSED_FLAGS_ADDR;
    endsequence

    sequence s_fault_read;
        bus_i.rd && bus_i.addr == `FAULT_STATUS_ADDR;
    endsequence

    sequence s_status_read;
        bus_i.rd && bus_i.addr == `EVT_STATUS_ADDR;
    endsequence

    sequence s_unpend_read;
        bus_i.rd && bus_i.addr == `UNPEND_ADDR;
    endsequence

    a_missed_read_back: assert property ( // RULE5
        @(posedge clk_i) disable iff (srst_i)
        s_missed_read |=> rdata_o == $past(missed_o)
    ) else $error("missed flag read does not match");

    a_fault_read_back: assert property ( // RULE12
        @(posedge clk_i) disable iff (srst_i)
        s_fault_read |=> rdata_o == {28'h000_0000, $past(fault_o)}
    ) else $error("fault status read does not match");

    a_status_read_back: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_status_read |=> rdata_o == {30'h0000_0000, $past(s_r.evt)}
    ) else $error("event status read does not match");

    a_unpend_reads_zero: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_unpend_read |=> rdata_o == 32'h0000_0000
    ) else $error("unpend read not zero");

    a_rdata_idle_zero: assert property (
        @(posedge clk_i) disable iff (srst_i)
        !bus_i.rd |=> rdata_o == 32'h0000_0000
    ) else $error("read data not zero without a read");

    // the reset edge loads zero rather than the input, so the edge after it is skipped
    a_active_mirror: assert property ( // RULE4
        @(posedge clk_i) disable iff (srst_i)
        !$past(srst_i) |-> s_r.active == (32'($past(active_i)) & `SRC_MASK)
    ) else $error("active state does not follow the core");

    a_fault_write_stores: assert property ( // RULE12
        @(posedge clk_i) disable iff (srst_i)
        s_fault_write ##0 !fault_i.valid |=> fault_o == $past(bus_i.wdata[3:0])
    ) else $error("fault status write not stored");

    a_fault_needs_cause: assert property ( // RULE12
        @(posedge clk_i) disable iff (srst_i)
        (fault_o & ~$past(fault_o)) != 4'h0
        |-> $past(fault_i.valid) || $past(bus_i.wr && bus_i.addr == `FAULT_STATUS_ADDR)
    ) else $error("fault flag rose without a cause");

    a_missed_needs_event: assert property ( // RULE6
        @(posedge clk_i) disable iff (srst_i)
        (missed_o & ~$past(missed_o)) != 32'h0000_0000
        |-> $past(|lost_w) || $past(bus_i.wr && bus_i.addr == `MISSED_FLAGS_ADDR)
    ) else $error("missed flag rose without a repeat event");

    a_pending_needs_source: assert property ( // RULE2
        @(posedge clk_i) disable iff (srst_i)
        (pending_o & ~$past(pending_o)) != 32'h0000_0000 |-> $past(|src_set_w)
    ) else $error("pending rose without a source");

    a_clear_drops_status: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_clear_write ##0 (!fault_i.valid && !(|lost_w))
        |=> (s_r.evt & $past(bus_i.wdata[1:0])) == 2'h0
    ) else $error("event clear did not clear status");

    a_enable_write_stored: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_enable_write |=> s_r.evt_en == $past(bus_i.wdata[1:0])
    ) else $error("event enable write not stored");

    a_irq_drops_disabled: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_enable_write ##0 (bus_i.wdata[1:0] == 2'h0) |=> !irq_o
    ) else $error("interrupt stayed high with all events disabled");

    a_fault_event_seen: assert property (
        @(posedge clk_i) disable iff (srst_i)
        fault_i.valid |=> s_r.evt[`EVT_BUS_FAULT_BIT]
    ) else $error("bus fault event not recorded");

    a_lost_event_seen: assert property ( // RULE6
        @(posedge clk_i) disable iff (srst_i)
        |lost_w |=> s_r.evt[`EVT_LOST_IRQ_BIT]
    ) else $error("missed interrupt event not recorded");

    a_unpend_event_wins: assert property (
        @(posedge clk_i) disable iff (srst_i)
        s_unpend_write ##0 (|ev_w) |=> (pending_o & $past(ev_w)) == $past(ev_w)
    ) else $error("same cycle event lost to unpend");

endmodule : irq_status_and_bus_fault_flags

`default_nettype wire

// [test/fault_source_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fault_source_model (
    input  wire logic                       clk_i,
    input  wire logic                       req_i,
    input  wire logic [2:0]                 cause_i,
    output var  irq_status_pkg::fault_info_t fault_o = '0
);
    // qualifiers toggle outside a fault, so a design reading them without valid shows it
    always @(posedge clk_i) begin
        fault_o.valid    <= req_i;
        fault_o.size_err <= req_i ? cause_i[2] : ~fault_o.size_err;
        fault_o.prot_err <= req_i ? cause_i[1] : ~fault_o.prot_err;
        fault_o.rsvd_err <= req_i ? cause_i[0] : ~fault_o.rsvd_err;
    end
endmodule : fault_source_model
`default_nettype wire

// [test/test_irq_status_and_bus_fault_flags.sv]
`timescale 1ns/10ps
`default_nettype none
`include "irq_status_regs.svh"
module test_irq_status_and_bus_fault_flags;
    localparam logic [31:0] SRC_M  = 32'h0001_D7BC;
    localparam logic [31:0] MISS_M = 32'h0000_D7BC;
    logic                        clk_i    = 1'b0;
    logic                        srst_i   = 1'b1;
    irq_status_pkg::bus_req_t    bus      = '0;
    irq_status_pkg::fault_info_t fault;
    logic [31:0]                 rdata_o, pending_o, missed_o, v, p;
    logic [3:0]                  fault_o;
    logic                        irq_o;
    logic [16:0]                 src_ev   = '0;
    logic [16:0]                 pend_set = '0;
    logic [16:0]                 act      = '0;
    logic                        f_req    = 1'b0;
    logic [2:0]                  f_cause  = '0;
    logic                        rd_q     = 1'b0;
    logic [31:0]                 expq[$];
    int                          miscompares = 0;
    int                          n_tests     = 0;
    int                          seed        = 32'h0000_8cc3;

    always #25 clk_i = ~clk_i;

    irq_status_and_bus_fault_flags u_irq_status_and_bus_fault_flags (
        .clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata_o),
        .src_event_i(src_ev), .pend_set_i(pend_set), .active_i(act),
        .fault_i(fault), .pending_o(pending_o), .missed_o(missed_o),
        .fault_o(fault_o), .irq_o(irq_o));
    fault_source_model u_fault_source_model (
        .clk_i(clk_i), .req_i(f_req), .cause_i(f_cause), .fault_o(fault));

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : cmp
    // one struct assignment per edge, so back-to-back strobes never double-drive
    task automatic op(input logic r, input logic w, input logic [31:0] a, input logic [31:0] d);
        bus <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge clk_i);
    endtask : op
    task automatic idle();
        op(1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    endtask : idle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        op(1'b0, 1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expq.push_back(e);
        op(1'b1, 1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic flt(input logic [2:0] c);
        f_cause <= c;
        f_req   <= 1'b1;
        idle();
        f_req <= 1'b0;
        idle();
        idle();
    endtask : flt
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_q) cmp(expq.pop_front(), rdata_o);
        rd_q <= bus.rd;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        idle();
        cmp(32'h0000_0000, pending_o | missed_o);
        cmp(32'h0000_0000, {27'h000_0000, irq_o, fault_o});
        rd(`MISSED_FLAGS_ADDR, 32'h0000_0000);
        rd(`ACTIVE_STATUS_ADDR, 32'h0000_0000);
        rd(`FAULT_STATUS_ADDR, 32'h0000_0000);
        rd(32'h4000_A824, 32'h0000_0000);
        idle();
        $display("reset test done");
        src_ev <= 17'h1_FFFF;
        idle();
        src_ev <= '0;
        idle();
        cmp(SRC_M, pending_o);
        cmp(32'h0000_0000, missed_o);
        src_ev <= 17'h1_FFFF;
        idle();
        src_ev <= '0;
        idle();
        cmp(MISS_M, missed_o);
        rd(`MISSED_FLAGS_ADDR, MISS_M);
        p = SRC_M;
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            wr(`UNPEND_ADDR, v);
            idle();
            p = p & ~v;
            cmp(p, pending_o);
        end
        rd(`UNPEND_ADDR, 32'h0000_0000);
        v = $random(seed);
        wr(`MISSED_FLAGS_ADDR, v);
        rd(`MISSED_FLAGS_ADDR, v & MISS_M);
        idle();
        cmp(v & MISS_M, missed_o);
        pend_set <= 17'h1_FFFF;
        idle();
        pend_set <= '0;
        idle();
        cmp(SRC_M, pending_o);
        cmp(v & MISS_M, missed_o);
        src_ev <= 17'h0_0004;
        wr(`UNPEND_ADDR, 32'hFFFF_FFFF);
        src_ev <= '0;
        idle();
        cmp(32'h0000_0004, pending_o);
        cmp((v & MISS_M) | 32'h0000_0004, missed_o);
        $display("source test done");
        v = $random(seed);
        act <= v[16:0];
        idle();
        idle();
        rd(`ACTIVE_STATUS_ADDR, {15'h0000, v[16:0]} & SRC_M);
        wr(`ACTIVE_STATUS_ADDR, 32'hFFFF_FFFF);
        rd(`ACTIVE_STATUS_ADDR, {15'h0000, v[16:0]} & SRC_M);
        idle();
        $display("active test done");
        for (int i = 0; i < 3; i++) begin
            wr(`FAULT_STATUS_ADDR, 32'h0000_0000);
            flt(3'b100 >> i);
            cmp(32'h0000_0008 >> i, {28'h000_0000, fault_o});
            idle();
            rd(`FAULT_STATUS_ADDR, 32'h0000_0008 >> i);
        end
        flt(3'b100);
        cmp(32'h0000_000B, {28'h000_0000, fault_o});
        wr(`FAULT_STATUS_ADDR, 32'hFFFF_FFFF);
        rd(`FAULT_STATUS_ADDR, 32'h0000_000F);
        wr(`FAULT_STATUS_ADDR, 32'h0000_0000);
        idle();
        cmp(32'h0000_0000, {28'h000_0000, fault_o});
        f_cause <= 3'b100;
        f_req   <= 1'b1;
        idle();
        f_req <= 1'b0;
        wr(`FAULT_STATUS_ADDR, 32'h0000_0000);
        idle();
        cmp(32'h0000_0008, {28'h000_0000, fault_o});
        $display("fault test done");
        wr(`EVT_ENABLE_ADDR, 32'h0000_0003);
        wr(`EVT_CLEAR_ADDR, 32'h0000_0003);
        idle();
        cmp(32'h0000_0000, {31'h0000_0000, irq_o});
        flt(3'b010);
        cmp(32'h0000_0001, {31'h0000_0000, irq_o});
        rd(`EVT_STATUS_ADDR, 32'h0000_0002);
        wr(`EVT_CLEAR_ADDR, 32'h0000_0002);
        wr(`EVT_ENABLE_ADDR, 32'h0000_0000);
        flt(3'b001);
        cmp(32'h0000_0000, {31'h0000_0000, irq_o});
        rd(`EVT_STATUS_ADDR, 32'h0000_0002);
        idle();
        idle();
        $display("interrupt test done");
        srst_i <= 1'b1;
        idle();
        idle();
        srst_i <= 1'b0;
        idle();
        cmp(32'h0000_0000, pending_o | missed_o);
        cmp(32'h0000_0000, {27'h000_0000, irq_o, fault_o});
        rd(`EVT_STATUS_ADDR, 32'h0000_0000);
        rd(`MISSED_FLAGS_ADDR, 32'h0000_0000);
        idle();
        idle();
        $display("reset again test done");
        conclude();
    end
endmodule : test_irq_status_and_bus_fault_flags
`default_nettype wire
